// ### src/bdc_pkg.sv
// Constants and types for the background debug command executor.
// Functional notes
// - Read data/address register, return contents
// - Write operand into named data/address register
// - Read system register; all supervisor-readable ones
// - Write operand into selected system register
// - Memory read, sized, space from source code
// - Memory write, space from destination code
// - Dump returns next operand after initial read
// - Resume: flush, refill pipe, leave debug mode
// - Patch: stack PC at SP-4, run patch
// - Peripheral reset active 512 cycles, core untouched
// - Null command changes no state
package bdc_pkg;
    localparam int unsigned RST_PULSE_CYCLES = 512;
    localparam int unsigned REG_SEL_W = 4;
    localparam int unsigned SYSREG_CNT = 8;
    localparam logic [2:0] SYS_PC = 3'h0;
    localparam logic [2:0] SYS_SR = 3'h1;
    localparam logic [2:0] SYS_USP = 3'h2;
    localparam logic [2:0] SYS_SSP = 3'h3;
    localparam logic [2:0] SYS_VBR = 3'h4;
    localparam logic [2:0] SYS_SRC_SPACE = 3'h5;
    localparam logic [2:0] SYS_DST_SPACE = 3'h6;
    localparam logic [2:0] SYS_ATEMP = 3'h7;
    localparam logic [4:0] FILL_LEN = 5'h10;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] SR_RESET = 32'h0000_2700;
    typedef enum logic [3:0] {
        BDC_NOP,
        BDC_RD_REG,
        BDC_WRREG,
        BDC_RSYS,
        BDC_WSYS,
        BDC_READ,
        BDC_WRITE,
        BDC_DUMP,
        BDC_FILL,
        BDC_GO,
        BDC_CALL,
        BDC_RST
    } bdc_cmd_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_MEM,
        ST_STACK,
        ST_FLUSH,
        ST_RUN,
        ST_PRST
    } bdc_state_t;
endpackage

// ### src/bdc_exec.sv
// Background debug command executor: decodes host commands and runs them on the core state.
`timescale 1ns/1ns
module bdc_exec #(
    parameter int unsigned RST_CYCLES = bdc_pkg::RST_PULSE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire bdc_pkg::bdc_cmd_t i_cmd,
    input wire logic [bdc_pkg::REG_SEL_W-1:0] i_reg_sel,
    input wire logic [1:0] i_size,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_operand,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    input wire logic i_core_halted,
    output logic o_cmd_ready,
    output logic o_resp_valid,
    output logic [31:0] o_resp_data,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [1:0] o_mem_size,
    output logic [2:0] o_mem_space,
    output logic [31:0] o_mem_wdata,
    output logic o_pipe_flush,
    output logic o_resume,
    output logic o_periph_reset
);
    import bdc_pkg::*;

    localparam int unsigned CNT_W = $clog2(RST_CYCLES + 1);

    logic [31:0] gpr_ff [16];
    logic [31:0] nxt_gpr [16];
    logic [31:0] sys_ff [SYSREG_CNT];
    logic [31:0] nxt_sys [SYSREG_CNT];
    bdc_state_t state_ff, nxt_state;
    logic [31:0] ptr_ff, nxt_ptr;
    logic [1:0] size_ff, nxt_size;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic cmd_ready_ff, nxt_cmd_ready;
    logic resp_valid_ff, nxt_resp_valid;
    logic [31:0] resp_data_ff, nxt_resp_data;
    logic mem_req_ff, nxt_mem_req;
    logic mem_we_ff, nxt_mem_we;
    logic [31:0] mem_addr_ff, nxt_mem_addr;
    logic [1:0] mem_size_ff, nxt_mem_size;
    logic [2:0] mem_space_ff, nxt_mem_space;
    logic [31:0] mem_wdata_ff, nxt_mem_wdata;
    logic flush_ff, nxt_flush;
    logic resume_ff, nxt_resume;
    logic prst_ff, nxt_prst;

    // Byte count of one sized access; used for every pointer step.
    function automatic logic [31:0] size_step(input logic [1:0] sz);
        size_step = (sz == SZ_BYTE) ? 32'h1 : ((sz == SZ_WORD) ? 32'h2 : 32'h4);
    endfunction

    wire take = i_cmd_valid && cmd_ready_ff;
    wire [31:0] sp_now = gpr_ff[15];

    always_comb begin
        nxt_state = state_ff;
        nxt_gpr = gpr_ff;
        nxt_sys = sys_ff;
        nxt_ptr = ptr_ff;
        nxt_size = size_ff;
        nxt_cnt = cnt_ff;
        nxt_cmd_ready = cmd_ready_ff;
        nxt_resp_valid = 1'b0;
        nxt_resp_data = resp_data_ff;
        nxt_mem_req = mem_req_ff;
        nxt_mem_we = mem_we_ff;
        nxt_mem_addr = mem_addr_ff;
        nxt_mem_size = mem_size_ff;
        nxt_mem_space = mem_space_ff;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_flush = 1'b0;
        nxt_resume = 1'b0;
        nxt_prst = prst_ff;
        unique case (state_ff)
            ST_IDLE: begin
                // One command in flight at a time, so answers leave in issue order.
                nxt_cmd_ready = i_core_halted;
                if (take) begin
                    unique case (i_cmd)
                        BDC_NOP: begin
                            nxt_cmd_ready = 1'b1;
                        end
                        BDC_RD_REG: begin
                            nxt_resp_valid = 1'b1;
                            nxt_resp_data = gpr_ff[i_reg_sel];
                        end
                        BDC_WRREG: begin
                            nxt_gpr[i_reg_sel] = i_operand;
                        end
                        BDC_RSYS: begin
                            nxt_resp_valid = 1'b1;
                            nxt_resp_data = sys_ff[i_reg_sel[2:0]];
                        end
                        BDC_WSYS: begin
                            nxt_sys[i_reg_sel[2:0]] = i_operand;
                        end
                        BDC_READ, BDC_DUMP: begin
                            nxt_cmd_ready = 1'b0;
                            nxt_state = ST_MEM;
                            nxt_mem_req = 1'b1;
                            nxt_mem_we = 1'b0;
                            nxt_mem_space = sys_ff[SYS_SRC_SPACE][2:0];
                            if (i_cmd == BDC_READ) begin
                                nxt_mem_addr = i_addr;
                                nxt_mem_size = i_size;
                                nxt_size = i_size;
                            end else begin
                                nxt_mem_addr = ptr_ff + size_step(size_ff);
                                nxt_mem_size = size_ff;
                            end
                        end
                        BDC_WRITE, BDC_FILL: begin
                            nxt_cmd_ready = 1'b0;
                            nxt_state = ST_MEM;
                            nxt_mem_req = 1'b1;
                            nxt_mem_we = 1'b1;
                            nxt_mem_wdata = i_operand;
                            nxt_mem_space = sys_ff[SYS_DST_SPACE][2:0];
                            if (i_cmd == BDC_WRITE) begin
                                nxt_mem_addr = i_addr;
                                nxt_mem_size = i_size;
                                nxt_size = i_size;
                            end else begin
                                nxt_mem_addr = ptr_ff + size_step(size_ff);
                                nxt_mem_size = size_ff;
                            end
                        end
                        BDC_GO: begin
                            nxt_cmd_ready = 1'b0;
                            nxt_flush = 1'b1;
                            nxt_state = ST_FLUSH;
                        end
                        BDC_CALL: begin
                            // The PC goes to the stack as one long word below the current SP.
                            nxt_cmd_ready = 1'b0;
                            nxt_gpr[15] = sp_now - 32'h4;
                            nxt_mem_req = 1'b1;
                            nxt_mem_we = 1'b1;
                            nxt_mem_addr = sp_now - 32'h4;
                            nxt_mem_size = SZ_LONG;
                            nxt_mem_space = sys_ff[SYS_DST_SPACE][2:0];
                            nxt_mem_wdata = sys_ff[SYS_PC];
                            nxt_sys[SYS_PC] = i_operand;
                            nxt_state = ST_STACK;
                        end
                        BDC_RST: begin
                            nxt_cmd_ready = 1'b0;
                            nxt_prst = 1'b1;
                            nxt_cnt = CNT_W'(RST_CYCLES - 1);
                            nxt_state = ST_PRST;
                        end
                        default: begin
                            nxt_cmd_ready = 1'b1;
                        end
                    endcase
                end
            end
            ST_MEM: begin
                if (i_mem_ack) begin
                    nxt_mem_req = 1'b0;
                    nxt_ptr = mem_addr_ff;
                    nxt_resp_valid = !mem_we_ff;
                    nxt_resp_data = i_mem_rdata;
                    nxt_cmd_ready = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_STACK: begin
                if (i_mem_ack) begin
                    nxt_mem_req = 1'b0;
                    nxt_flush = 1'b1;
                    nxt_state = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                // Pipe refill is one cycle after the flush pulse, then execution restarts.
                nxt_resume = 1'b1;
                nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (i_core_halted && !resume_ff) begin
                    nxt_cmd_ready = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_PRST: begin
                if (cnt_ff == '0) begin
                    nxt_prst = 1'b0;
                    nxt_cmd_ready = 1'b1;
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
            for (int i = 0; i < 16; i++) begin
                gpr_ff[i] <= RESET_WORD;
            end
            for (int i = 0; i < SYSREG_CNT; i++) begin
                sys_ff[i] <= (i == SYS_SR) ? SR_RESET : RESET_WORD;
            end
            ptr_ff <= RESET_WORD;
            size_ff <= SZ_LONG;
            cnt_ff <= '0;
            cmd_ready_ff <= 1'b0;
            resp_valid_ff <= 1'b0;
            resp_data_ff <= RESET_WORD;
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_addr_ff <= RESET_WORD;
            mem_size_ff <= SZ_LONG;
            mem_space_ff <= 3'h0;
            mem_wdata_ff <= RESET_WORD;
            flush_ff <= 1'b0;
            resume_ff <= 1'b0;
            prst_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            gpr_ff <= nxt_gpr;
            sys_ff <= nxt_sys;
            ptr_ff <= nxt_ptr;
            size_ff <= nxt_size;
            cnt_ff <= nxt_cnt;
            cmd_ready_ff <= nxt_cmd_ready;
            resp_valid_ff <= nxt_resp_valid;
            resp_data_ff <= nxt_resp_data;
            mem_req_ff <= nxt_mem_req;
            mem_we_ff <= nxt_mem_we;
            mem_addr_ff <= nxt_mem_addr;
            mem_size_ff <= nxt_mem_size;
            mem_space_ff <= nxt_mem_space;
            mem_wdata_ff <= nxt_mem_wdata;
            flush_ff <= nxt_flush;
            resume_ff <= nxt_resume;
            prst_ff <= nxt_prst;
        end
    end

    assign o_cmd_ready = cmd_ready_ff;
    assign o_resp_valid = resp_valid_ff;
    assign o_resp_data = resp_data_ff;
    assign o_mem_req = mem_req_ff;
    assign o_mem_we = mem_we_ff;
    assign o_mem_addr = mem_addr_ff;
    assign o_mem_size = mem_size_ff;
    assign o_mem_space = mem_space_ff;
    assign o_mem_wdata = mem_wdata_ff;
    assign o_pipe_flush = flush_ff;
    assign o_resume = resume_ff;
    assign o_periph_reset = prst_ff;

    property p_rd_reg;
        @(posedge i_clk) disable iff (i_rst)
        (take && i_cmd == BDC_RD_REG) |=> (resp_valid_ff && resp_data_ff == $past(gpr_ff[i_reg_sel]));
    endproperty
    a_rd_reg: assert property (p_rd_reg) else $error("register read did not answer next cycle");

    property p_wrreg;
        @(posedge i_clk) disable iff (i_rst)
        (take && i_cmd == BDC_WRREG) |=> (gpr_ff[$past(i_reg_sel)] == $past(i_operand));
    endproperty
    a_wrreg: assert property (p_wrreg) else $error("register write not stored");

    property p_wsys;
        @(posedge i_clk) disable iff (i_rst)
        (take && i_cmd == BDC_WSYS) |=> (sys_ff[$past(i_reg_sel[2:0])] == $past(i_operand));
    endproperty
    a_wsys: assert property (p_wsys) else $error("system register write not stored");

    property p_rdspace;
        @(posedge i_clk) disable iff (i_rst)
        (take && i_cmd == BDC_READ) |=> (mem_req_ff && !mem_we_ff && mem_space_ff == sys_ff[SYS_SRC_SPACE][2:0]);
    endproperty
    a_rdspace: assert property (p_rdspace) else $error("memory read used wrong space");

    property p_wrspace;
        @(posedge i_clk) disable iff (i_rst)
        (take && i_cmd == BDC_WRITE) |=> (mem_req_ff && mem_we_ff && mem_space_ff == sys_ff[SYS_DST_SPACE][2:0]);
    endproperty
    a_wrspace: assert property (p_wrspace) else $error("memory write used wrong space");

    property p_dump;
        @(posedge i_clk) disable iff (i_rst)
        (take && i_cmd == BDC_DUMP) |=> (mem_addr_ff == $past(ptr_ff) + size_step($past(size_ff)));
    endproperty
    a_dump: assert property (p_dump) else $error("dump address did not advance");

    property p_go;
        @(posedge i_clk) disable iff (i_rst)
        (take && i_cmd == BDC_GO) |=> flush_ff ##1 resume_ff;
    endproperty
    a_go: assert property (p_go) else $error("resume sequence wrong");

    // Helper count of the pulse high time; only the length check reads it, so the check is exact at any length.
    logic [CNT_W-1:0] prst_len_ff, nxt_prst_len;
    always_comb begin
        nxt_prst_len = prst_ff ? (prst_len_ff + CNT_W'(1)) : '0;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prst_len_ff <= '0;
        end else begin
            prst_len_ff <= nxt_prst_len;
        end
    end

    property p_rst_len;
        @(posedge i_clk) disable iff (i_rst)
        $fell(prst_ff) |-> (prst_len_ff == CNT_W'(RST_CYCLES));
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("peripheral reset pulse length wrong");

    property p_nop;
        @(posedge i_clk) disable iff (i_rst)
        (take && i_cmd == BDC_NOP) |=> (!resp_valid_ff && !mem_req_ff && !flush_ff && !prst_ff &&
            gpr_ff[$past(i_reg_sel)] == $past(gpr_ff[i_reg_sel]) && sys_ff[SYS_PC] == $past(sys_ff[SYS_PC]));
    endproperty
    a_nop: assert property (p_nop) else $error("null command changed state");
endmodule

// ### tb/bdc_mem_model.sv
// Memory and core-run partner model for the debug command executor.
`timescale 1ns/1ns
module bdc_mem_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_mem_req,
    input wire logic i_mem_we,
    input wire logic [31:0] i_mem_addr,
    input wire logic [1:0] i_mem_size,
    input wire logic [2:0] i_mem_space,
    input wire logic [31:0] i_mem_wdata,
    input wire logic i_resume,
    output logic o_mem_ack,
    output logic [31:0] o_mem_rdata,
    output logic o_core_halted
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] last_addr;
    logic [31:0] last_wdata;
    logic [1:0] last_size;
    logic [2:0] last_space;
    logic last_we;
    int req_cnt;
    int wait_cnt;
    int run_cnt;
    // Ack delay rotates 0..3 so both prompt and slow answers occur.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mem_ack <= 1'b0;
            o_mem_rdata <= 32'h0;
            req_cnt <= 0;
            wait_cnt <= 0;
        end else begin
            o_mem_ack <= 1'b0;
            // Released data lines show a changing pattern, never the last value.
            o_mem_rdata <= ~o_mem_rdata;
            if (i_mem_req && !o_mem_ack) begin
                if (wait_cnt == 0) begin
                    o_mem_ack <= 1'b1;
                    o_mem_rdata <= mem.exists(i_mem_addr) ? mem[i_mem_addr] : ~i_mem_addr;
                    if (i_mem_we) begin
                        mem[i_mem_addr] = i_mem_wdata;
                    end
                    last_addr <= i_mem_addr;
                    last_wdata <= i_mem_wdata;
                    last_size <= i_mem_size;
                    last_space <= i_mem_space;
                    last_we <= i_mem_we;
                    req_cnt <= req_cnt + 1;
                    wait_cnt <= req_cnt % 4;
                end else begin
                    wait_cnt <= wait_cnt - 1;
                end
            end
        end
    end
    // The core runs for a few cycles after a resume, then halts again.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_core_halted <= 1'b1;
            run_cnt <= 0;
        end else if (i_resume) begin
            o_core_halted <= 1'b0;
            run_cnt <= 6;
        end else if (run_cnt > 0) begin
            run_cnt <= run_cnt - 1;
            o_core_halted <= (run_cnt == 1);
        end
    end
endmodule

// ### tb/background_debug_commands_tb_top.sv
// Self-checking testbench for the debug command executor.
`timescale 1ns/1ns
module background_debug_commands_tb_top;
    import bdc_pkg::*;
    localparam int RC = 8;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_cmd_valid = 1'b0;
    bdc_cmd_t i_cmd = BDC_NOP;
    logic [3:0] i_reg_sel = 4'h0;
    logic [1:0] i_size = 2'h0;
    logic [31:0] i_addr = 32'h0;
    logic [31:0] i_operand = 32'h0;
    logic ack, halted, rdy, rv, req, we, flush, res, prst;
    logic [31:0] rdata, rd, ma, wd;
    logic [1:0] ms;
    logic [2:0] sp;
    logic [31:0] resp_q [$];
    logic [31:0] v, a0, b0, r, pc0, pc1, sp0, base, msk;
    logic [2:0] src_sp, dst_sp;
    logic [31:0] wv [4];
    int req0;
    int seed = 32'h0d9e;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    always #4 i_clk = ~i_clk;
    bdc_exec #(.RST_CYCLES(RC)) u_bdc_exec (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd), .i_reg_sel(i_reg_sel), .i_size(i_size), .i_addr(i_addr), .i_operand(i_operand),
        .i_mem_ack(ack), .i_mem_rdata(rdata), .i_core_halted(halted), .o_cmd_ready(rdy),
        .o_resp_valid(rv), .o_resp_data(rd), .o_mem_req(req), .o_mem_we(we), .o_mem_addr(ma),
        .o_mem_size(ms), .o_mem_space(sp), .o_mem_wdata(wd), .o_pipe_flush(flush), .o_resume(res),
        .o_periph_reset(prst));
    bdc_mem_model u_bdc_mem_model (.i_clk(i_clk), .i_rst(i_rst), .i_mem_req(req), .i_mem_we(we),
        .i_mem_addr(ma), .i_mem_size(ms), .i_mem_space(sp), .i_mem_wdata(wd), .i_resume(res),
        .o_mem_ack(ack), .o_mem_rdata(rdata), .o_core_halted(halted));
    always @(posedge i_clk) begin
        if (rv === 1'b1) resp_q.push_back(rd);
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_ready();
        int t;
        t = 0;
        while (rdy !== 1'b1 && t < 300) begin
            @(posedge i_clk);
            #1;
            t++;
        end
        if (t == 300) chk("ready", 32'h0, 32'h1);
    endtask
    // Returns 1ns after the take edge, with valid already dropped.
    // One edge passes first, so valid never falls and rises in the same time step.
    task automatic issue(input logic [3:0] c, input logic [3:0] s, input logic [1:0] z,
                         input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        #1;
        wait_ready();
        i_cmd_valid = 1'b1;
        i_cmd = bdc_cmd_t'(c);
        i_reg_sel = s;
        i_size = z;
        i_addr = a;
        i_operand = d;
        @(posedge i_clk);
        #1;
        i_cmd_valid = 1'b0;
    endtask
    task automatic get_resp(output logic [31:0] d);
        int t;
        t = 0;
        while (resp_q.size() == 0 && t < 100) begin
            @(posedge i_clk);
            #1;
            t++;
        end
        d = (resp_q.size() > 0) ? resp_q.pop_front() : 32'hx;
    endtask
    task automatic rd_cmd(input logic [3:0] c, input logic [3:0] s, output logic [31:0] d);
        issue(c, s, 2'h0, 32'h0, 32'h0);
        get_resp(d);
    endtask
    function automatic logic [31:0] step(input logic [1:0] z);
        return (z == 2'h0) ? 32'h1 : (z == 2'h1) ? 32'h2 : 32'h4;
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            issue(4'h2, i[3:0] * 4'h3, 2'h0, 32'h0, v);
            rd_cmd(4'h1, i[3:0] * 4'h3, r);
            chk("reg", r, v);
        end
        a0 = $random(seed);
        b0 = $random(seed);
        issue(4'h2, 4'h0, 2'h0, 32'h0, a0);
        issue(4'h2, 4'h8, 2'h0, 32'h0, b0);
        issue(4'h1, 4'h0, 2'h0, 32'h0, 32'h0);
        issue(4'h1, 4'h8, 2'h0, 32'h0, 32'h0);
        get_resp(r);
        chk("order0", r, a0);
        get_resp(r);
        chk("order1", r, b0);
        $display("registers done");
        rd_cmd(4'h3, {1'b0, SYS_SR}, r);
        chk("sr", r, SR_RESET);
        src_sp = 3'($random(seed));
        dst_sp = ~src_sp;
        issue(4'h4, {1'b0, SYS_SRC_SPACE}, 2'h0, 32'h0, {29'h0, src_sp});
        issue(4'h4, {1'b0, SYS_DST_SPACE}, 2'h0, 32'h0, {29'h0, dst_sp});
        rd_cmd(4'h3, {1'b0, SYS_DST_SPACE}, r);
        chk("dst_space", r & 32'h7, {29'h0, dst_sp});
        $display("system registers done");
        for (int z = 0; z < 3; z++) begin
            base = $random(seed) & 32'h00ff_fff0;
            msk = (z == 0) ? 32'hff : (z == 1) ? 32'hffff : 32'hffff_ffff;
            for (int k = 0; k < 4; k++) begin
                v = ($random(seed) & msk) ^ k;
                wv[k] = v;
                issue((k == 0) ? 4'h6 : 4'h8, 4'h0, z[1:0], base, v);
                wait_ready();
                chk("waddr", u_bdc_mem_model.last_addr, base + k * step(z[1:0]));
                chk("wdata", u_bdc_mem_model.last_wdata, v);
                chk("wattr", {u_bdc_mem_model.last_we, u_bdc_mem_model.last_space, u_bdc_mem_model.last_size},
                    {1'b1, dst_sp, z[1:0]});
            end
            for (int k = 0; k < 4; k++) begin
                issue((k == 0) ? 4'h5 : 4'h7, 4'h0, z[1:0], base, 32'h0);
                get_resp(r);
                chk("rdata", r & msk, wv[k]);
                chk("raddr", u_bdc_mem_model.last_addr, base + k * step(z[1:0]));
                chk("rattr", {u_bdc_mem_model.last_we, u_bdc_mem_model.last_space, u_bdc_mem_model.last_size},
                    {1'b0, src_sp, z[1:0]});
            end
        end
        $display("memory done");
        req0 = u_bdc_mem_model.req_cnt;
        issue(4'h0, 4'h0, 2'h0, 32'h0, 32'h0);
        issue(4'hc, 4'h0, 2'h0, 32'h0, 32'h0);
        rd_cmd(4'h1, 4'h0, r);
        chk("nop", r, a0);
        chk("nop_mem", u_bdc_mem_model.req_cnt, req0);
        issue(4'hb, 4'h0, 2'h0, 32'h0, 32'h0);
        n = 0;
        while (prst === 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("prst_len", n, RC);
        $display("null and reset done");
        pc0 = $random(seed) & 32'hffff_fffe;
        pc1 = $random(seed) & 32'hffff_fffe;
        sp0 = $random(seed) & 32'h00ff_fffc;
        issue(4'h4, 4'h0, 2'h0, 32'h0, pc0);
        issue(4'h2, 4'hf, 2'h0, 32'h0, sp0);
        issue(4'ha, 4'h0, 2'h0, 32'h0, pc1);
        wait_ready();
        chk("stack_addr", u_bdc_mem_model.last_addr, sp0 - 32'h4);
        chk("stack_data", u_bdc_mem_model.last_wdata, pc0);
        rd_cmd(4'h3, 4'h0, r);
        chk("patch_pc", r, pc1);
        rd_cmd(4'h1, 4'hf, r);
        chk("patch_sp", r, sp0 - 32'h4);
        issue(4'h9, 4'h0, 2'h0, 32'h0, 32'h0);
        chk("flush", {31'h0, flush}, 32'h1);
        @(posedge i_clk);
        #1;
        chk("resume", {31'h0, res}, 32'h1);
        rd_cmd(4'h3, 4'h0, r);
        chk("go_pc", r, pc1);
        $display("patch and resume done");
        conclude();
    end
endmodule
